// file: verilog/ipf_pkg.sv
package ipf_pkg;
	localparam int          ADDR_W          = 12;
	localparam int          PRIO_W          = 3;
	localparam int          REG_W           = 16;
	localparam int          NUM_SRC         = 3;
	// register byte addresses: no offsets given, chosen here
	localparam logic [11:0] VD_PRIO_ADDR    = 12'h000;
	localparam logic [11:0] CM_PRIO_ADDR    = 12'h004;
	localparam logic [11:0] WU_PRIO_ADDR    = 12'h008;
	localparam logic [11:0] PEND_ADDR       = 12'h00C;
	localparam logic [11:0] LEVEL_ADDR      = 12'h010;
	// field positions
	localparam int          VD_LSB          = 0;
	localparam int          CM_LSB          = 4;
	localparam int          WU_LSB          = 0;
	localparam logic [2:0]  PRIO_RESET      = 3'h4;
	localparam logic [2:0]  PRIO_OFF        = 3'h0;
	localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
	localparam logic [2:0]  HSIZE_WORD      = 3'h2;
	localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
	typedef enum logic [1:0] {
		IPF_IDLE  = 2'b01,
		IPF_WRITE = 2'b10
	} ipf_phase_type;
endpackage : ipf_pkg

// file: verilog/ipf_src_if.sv
interface ipf_src_if;
	logic [2:0] prio;
	logic       raw;
	logic       req;
	logic [2:0] level;
	modport ctrl (output prio, output raw, input req, input level);
	modport src  (input prio, input raw, output req, output level);
endinterface : ipf_src_if

// file: verilog/ipf_src_gate.sv
module ipf_src_gate (
	ipf_src_if.src s
);
	// code 000 masks the source; 001..111 pass as priority 1..7
	always_comb begin
		s.req   = s.raw && (s.prio != ipf_pkg::PRIO_OFF);
		s.level = s.req ? s.prio : ipf_pkg::PRIO_OFF;
	end
endmodule : ipf_src_gate

// file: verilog/ipf_top.sv
// Summary of operation
// - code 111 means priority seven, highest
// - code 001 is priority one, linear between
// - code 000 disables the source
// - voltage field bits 2:0, upper bits zero
// - charge field bits 6:4, reset 100
// - charge bits 15:7 read zero
// - charge bits 3:0 read zero
// - wakeup field bits 2:0, upper bits zero
// - all fields reset to priority four
module ipf_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [2:0]  src_raw,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [2:0]  src_req,
	output logic      [2:0]  top_level
);
	logic [ipf_pkg::PRIO_W-1:0]  vd_reg;
	logic [ipf_pkg::PRIO_W-1:0]  vd_next;
	logic [ipf_pkg::PRIO_W-1:0]  cm_reg;
	logic [ipf_pkg::PRIO_W-1:0]  cm_next;
	logic [ipf_pkg::PRIO_W-1:0]  wu_reg;
	logic [ipf_pkg::PRIO_W-1:0]  wu_next;
	logic [ipf_pkg::ADDR_W-1:0]  wa_reg;
	logic [ipf_pkg::ADDR_W-1:0]  wa_next;
	ipf_pkg::ipf_phase_type      ph_reg;
	ipf_pkg::ipf_phase_type      ph_next;
	logic [31:0]                 rd_reg;
	logic [31:0]                 rd_next;
	logic                        rdy_reg;
	logic                        rdy_next;
	logic                        resp_reg;
	logic                        resp_next;
	logic [ipf_pkg::NUM_SRC-1:0] req_reg;
	logic [ipf_pkg::NUM_SRC-1:0] req_next;
	logic [ipf_pkg::PRIO_W-1:0]  lvl_reg;
	logic [ipf_pkg::PRIO_W-1:0]  lvl_next;
	logic [ipf_pkg::NUM_SRC-1:0] req_now;
	logic                        take;
	logic                        take_wr;
	logic                        take_rd;
	logic [ipf_pkg::PRIO_W-1:0]  lv [ipf_pkg::NUM_SRC];

	ipf_src_if sif [ipf_pkg::NUM_SRC] ();
	assign sif[0].prio = vd_reg;
	assign sif[1].prio = cm_reg;
	assign sif[2].prio = wu_reg;
	genvar g;
	generate
		for (g = 0; g < ipf_pkg::NUM_SRC; g++) begin : g_src
			assign sif[g].raw = src_raw[g];
			assign lv[g]      = sif[g].level;
			assign req_now[g] = sif[g].req;
			ipf_src_gate u_gate (.s(sif[g].src));
		end
	endgenerate

	assign hrdata    = rd_reg;
	assign hreadyout = rdy_reg;
	assign hresp     = resp_reg;
	assign src_req   = req_reg;
	assign top_level = lvl_reg;

	// sub-word accesses are not decoded, so a byte write cannot clip a field
	assign take    = hsel && hready && (htrans == ipf_pkg::HTRANS_NONSEQ) && (hsize == ipf_pkg::HSIZE_WORD);
	assign take_wr = take && hwrite;
	assign take_rd = take && !hwrite;

	// write address held until its data phase
	always_comb begin
		ph_next = ipf_pkg::IPF_IDLE;
		wa_next = wa_reg;
		if (take_wr) begin
			ph_next = ipf_pkg::IPF_WRITE;
			wa_next = haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_reg <= ipf_pkg::IPF_IDLE;
			wa_reg <= 12'h000;
		end else begin
			ph_reg <= ph_next;
			wa_reg <= wa_next;
		end
	end

	// only the field lanes are stored; other written bits are dropped
	always_comb begin
		vd_next = vd_reg;
		case (ph_reg)
			ipf_pkg::IPF_WRITE: begin
				if (wa_reg == ipf_pkg::VD_PRIO_ADDR) begin
					vd_next = hwdata[ipf_pkg::VD_LSB +: ipf_pkg::PRIO_W];
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vd_reg <= ipf_pkg::PRIO_RESET;
		end else begin
			vd_reg <= vd_next;
		end
	end

	// charge field sits in bits 6:4 of the low byte lane; bits around it are never stored
	always_comb begin
		cm_next = cm_reg;
		case (ph_reg)
			ipf_pkg::IPF_WRITE: begin
				if (wa_reg == ipf_pkg::CM_PRIO_ADDR) begin
					cm_next = hwdata[ipf_pkg::CM_LSB +: ipf_pkg::PRIO_W];
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cm_reg <= ipf_pkg::PRIO_RESET;
		end else begin
			cm_reg <= cm_next;
		end
	end

	// wakeup field
	always_comb begin
		wu_next = wu_reg;
		case (ph_reg)
			ipf_pkg::IPF_WRITE: begin
				if (wa_reg == ipf_pkg::WU_PRIO_ADDR) begin
					wu_next = hwdata[ipf_pkg::WU_LSB +: ipf_pkg::PRIO_W];
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wu_reg <= ipf_pkg::PRIO_RESET;
		end else begin
			wu_reg <= wu_next;
		end
	end

	// read data captured at address phase, stands in data phase only
	always_comb begin
		rd_next = ipf_pkg::ZERO_WORD;
		if (take_rd) begin
			if (haddr == ipf_pkg::VD_PRIO_ADDR) begin
				rd_next[ipf_pkg::VD_LSB +: ipf_pkg::PRIO_W] = vd_reg;
			end else if (haddr == ipf_pkg::CM_PRIO_ADDR) begin
				rd_next[ipf_pkg::CM_LSB +: ipf_pkg::PRIO_W] = cm_reg;
			end else if (haddr == ipf_pkg::WU_PRIO_ADDR) begin
				rd_next[ipf_pkg::WU_LSB +: ipf_pkg::PRIO_W] = wu_reg;
			end else if (haddr == ipf_pkg::PEND_ADDR) begin
				rd_next[ipf_pkg::NUM_SRC-1:0] = req_now;
			end else if (haddr == ipf_pkg::LEVEL_ADDR) begin
				rd_next[ipf_pkg::PRIO_W-1:0] = lvl_reg;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_reg <= ipf_pkg::ZERO_WORD;
		end else begin
			rd_reg <= rd_next;
		end
	end

	// zero wait states and no error response: nothing here is refused
	always_comb begin
		rdy_next  = 1'b1;
		resp_next = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdy_reg  <= 1'b1;
			resp_reg <= 1'b0;
		end else begin
			rdy_reg  <= rdy_next;
			resp_reg <= resp_next;
		end
	end

	// equal codes need no tie rule: the level is the code itself
	always_comb begin
		req_next = req_now;
		lvl_next = lv[0];
		if (lv[1] > lvl_next) begin
			lvl_next = lv[1];
		end
		if (lv[2] > lvl_next) begin
			lvl_next = lv[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_reg <= 3'h0;
			lvl_reg <= 3'h0;
		end else begin
			req_reg <= req_next;
			lvl_reg <= lvl_next;
		end
	end
endmodule : ipf_top

// file: tb/ipf_top_sva.sv
module ipf_sva (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [2:0]  src_raw,
	input wire logic [31:0] hrdata,
	input wire logic [2:0]  src_req,
	input wire logic [2:0]  top_level
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd;
	assign rd = hsel && hready && htrans == 2'h2 && !hwrite;
	vd_upper_a: assert property (rd && haddr == 12'h000 |=> hrdata[31:3] == 29'h0)
		else $error("voltage upper bits set");
	cm_upper_a: assert property (rd && haddr == 12'h004 |=> hrdata[31:7] == 25'h0)
		else $error("charge upper bits set");
	cm_lower_a: assert property (rd && haddr == 12'h004 |=> hrdata[3:0] == 4'h0)
		else $error("charge lower bits set");
	wu_upper_a: assert property (rd && haddr == 12'h008 |=> hrdata[31:3] == 29'h0)
		else $error("wakeup upper bits set");
	req_cause_a: assert property ((src_req & ~$past(src_raw)) == 3'h0)
		else $error("request without raw");
	lvl_none_a: assert property (src_req == 3'h0 |-> top_level == 3'h0)
		else $error("level without request");
	lvl_some_a: assert property (src_req != 3'h0 |-> top_level != 3'h0)
		else $error("request at level zero");
	lvl_read_a: assert property (rd && haddr == 12'h010 |=> hrdata == {29'h0, $past(top_level)})
		else $error("level read wrong");
	cover property (rd && haddr == 12'h004);
	cover property (top_level == 3'h7);
	cover property (src_req == 3'h3);
endmodule : ipf_sva

// file: tb/ipf_top_tb.sv
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t %h %h", $time, a, e); end end
module ipf_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hresp;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, r;
	logic [2:0]  src_raw = 3'h0, src_req, top_level;
	int          n_mismatch = 0, check_count = 0;
	always #50 hclk = ~hclk;
	// hready is fed back from the single slave
	ipf_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
		.src_raw, .hrdata, .hreadyout(hready), .hresp, .src_req, .top_level);
	task end_of_test;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task wait_rdy;
		int i;
		i = 0;
		do begin @(posedge hclk); i++; end while (hready !== 1'b1 && i < 20);
		if (hready !== 1'b1) begin n_mismatch++; end_of_test; end
	endtask : wait_rdy
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	endtask : xfer
	task t_fields;
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, 12'h000, 32'hFFFF_FFF8 | 32'(c));
			xfer(1'b1, 12'h004, 32'hFFFF_FF8F | (32'(c) << 4));
			xfer(1'b1, 12'h008, 32'hFFFF_FFF8 | 32'(c));
			xfer(1'b0, 12'h000, 32'h0);
			`CHK(r, 32'(c))
			xfer(1'b0, 12'h004, 32'h0);
			`CHK(r, 32'(c) << 4)
			xfer(1'b0, 12'h008, 32'h0);
			`CHK(r, 32'(c))
		end
		xfer(1'b0, 12'h020, 32'h0);
		`CHK(r, 32'h0)
		xfer(1'b1, 12'h00C, 32'h0);
		`CHK(hresp, 1'b0)
		xfer(1'b1, 12'h020, 32'h0);
		`CHK(hresp, 1'b0)
		xfer(1'b0, 12'h000, 32'h0);
		`CHK(r, 32'h7)
	endtask : t_fields
	task t_prio;
		xfer(1'b1, 12'h000, 32'h7);
		xfer(1'b1, 12'h004, 32'h10);
		xfer(1'b1, 12'h008, 32'h0);
		src_raw <= 3'h7;
		repeat (2) @(posedge hclk);
		#1;
		`CHK(src_req, 3'h3)
		`CHK(top_level, 3'h7)
		@(posedge hclk);
		src_raw <= 3'h6;
		repeat (2) @(posedge hclk);
		#1;
		`CHK(top_level, 3'h1)
		xfer(1'b0, 12'h010, 32'h0);
		`CHK(r, 32'h1)
		xfer(1'b0, 12'h00C, 32'h0);
		`CHK(r, 32'h2)
	endtask : t_prio
	task t_reset_vals;
		xfer(1'b0, 12'h000, 32'h0);
		`CHK(r, 32'h4)
		xfer(1'b0, 12'h004, 32'h0);
		`CHK(r, 32'h40)
		xfer(1'b0, 12'h008, 32'h0);
		`CHK(r, 32'h4)
	endtask : t_reset_vals
	task t_midreset;
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset_vals;
	endtask : t_midreset
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_vals;
		t_fields;
		t_prio;
		t_midreset;
		end_of_test;
	end
endmodule : ipf_top_tb
bind ipf_top ipf_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .src_raw, .hrdata, .src_req,
	.top_level);
